// ===== verilog/adcs_pkg.sv
// constants, field layouts and carrier types of the converter control sequencer
package adcs_pkg;
   // bus geometry: register index sits in paddr[9:2]
   localparam int ABUS_W = 10;
   localparam int IDX_W = 8;
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CLK_CHAN = 8'h1f;
   localparam logic [IDX_W-1:0] IDX_FMT_CFG = 8'h9f;
   localparam logic [IDX_W-1:0] IDX_RES_HIGH = 8'h1e;
   localparam logic [IDX_W-1:0] IDX_RES_LOW = 8'h9e;
   localparam logic [IDX_W-1:0] IDX_ACQ = 8'ha0;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'ha1;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'ha2;
   // reset values
   localparam logic [7:0] RST_CLK_CHAN = 8'h00;
   localparam logic [7:0] RST_FMT_CFG = 8'h00;
   localparam logic [2:0] RST_ACQ = 3'h0;
   localparam logic [9:0] RST_RESULT = 10'h000;
   localparam logic [7:0] RST_IRQ = 8'h00;
   // field positions
   localparam int ACQ_LSB = 3;
   localparam int DONE_BIT = 0;
   // converter geometry and timing; conversion length in conversion-bit periods, dividers in system clocks
   localparam int RES_W = 10;
   localparam int NUM_CHAN = 14;
   localparam logic [3:0] CONV_TADS = 4'hc;
   localparam logic [9:0] FULL_SCALE = 10'h3ff;
   localparam logic [1:0] CS_RC = 2'h3;
   localparam int DIV_BASE = 2;
   localparam int DIV_MAX = 64;

   // first control register, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] conv_clock_select;
      logic [2:0] chan_low;
      logic go;
      logic channel_select_msb;
      logic converter_power_on;
   } adcs_clk_chan_t;

   // second control register, bit 7 down to bit 0
   typedef struct packed {
      logic result_justify;
      logic clock_halve_select;
      logic neg_ref_select;
      logic pos_ref_select;
      logic [3:0] pin_analog_config;
   } adcs_fmt_cfg_t;

   // acquisition length in conversion-bit periods
   function automatic logic [4:0] acq_tads(input logic [2:0] code);
      case (code)
         3'h0: acq_tads = 5'h00;
         3'h1: acq_tads = 5'h02;
         3'h2: acq_tads = 5'h04;
         3'h3: acq_tads = 5'h06;
         3'h4: acq_tads = 5'h08;
         3'h5: acq_tads = 5'h0c;
         3'h6: acq_tads = 5'h10;
         default: acq_tads = 5'h14;
      endcase
   endfunction
endpackage

// ===== verilog/adcs_tad_gen.sv
// conversion-bit period tick generator from the system or internal rc clock
`timescale 1ns/10ps
`default_nettype none
module adcs_tad_gen #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // control
   input wire logic run_i,
   input wire logic [1:0] sel_i,
   input wire logic halve_i,
   // internal rc clock pin
   input wire logic rc_clk_i,
   // one-cycle tick per conversion-bit period
   output logic tick_o
);
   import adcs_pkg::*;

   if ((1 << CNT_W) < DIV_MAX) begin : g_chk
      $error("adcs_tad_gen: CNT_W too small for the largest divider");
   end

   // last count of the system clock divider
   function automatic logic [CNT_W-1:0] div_last(input logic [1:0] s, input logic h);
      int d;
      d = DIV_BASE << (2 * int'(s) + int'(h));
      div_last = CNT_W'(d - 1);
   endfunction

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic rc_m_r;
   logic rc_s_r;
   logic rc_d_r;
   wire logic use_rc;
   wire logic rc_edge;
   wire logic div_wrap;
   wire logic tick_nxt;

   // rc edges are found in the system domain, so completion lands there too
   assign use_rc = (sel_i == CS_RC);
   assign rc_edge = rc_s_r & ~rc_d_r;
   assign div_wrap = (cnt_r == div_last(sel_i, halve_i));
   assign tick_nxt = run_i & (use_rc ? rc_edge : div_wrap);
   // counter restarts on each run so the first period is whole
   assign cnt_nxt = (!run_i || div_wrap) ? '0 : cnt_r + CNT_W'(1);

   // rc pin synchroniser; the first stage feeds only the second
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         rc_m_r <= 1'b0;
         rc_s_r <= 1'b0;
         rc_d_r <= 1'b0;
      end else begin
         rc_m_r <= rc_clk_i;
         rc_s_r <= rc_m_r;
         rc_d_r <= rc_s_r;
      end
   end

   // divider and tick flop
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_o <= tick_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/adcs_ctrl.sv
// converter control sequencer: apb registers, acquisition and sar sequencing
// Notes on behaviour
// - writing go starts conversion; hardware clears it
// - power bit off shuts converter down
// - clock select picks fosc/2,/8,/32 or rc
// - halve bit doubles divides to 4,16,64
// - channel codes 0..13 route; 111x none
// - channel msb at bit 1, rest 5:3
// - missing small-package inputs give full scale
// - justify bit chooses right or left alignment
// - negative reference ground or external pin
// - positive reference supply or external pin
// - pin config turns inputs digital from top
// - sample for acquisition time before converting
// - each conversion yields a 10-bit value
// - finish loads result, clears go, flags done
// - acquisition code gives 0..20 bit periods
// - reset clears control and aborts conversion
// - conversion takes twelve bit periods
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module adcs_ctrl #(
   parameter int TAD_CNT_W = 6,
   parameter bit NARROW_PKG = 1'b0
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [adcs_pkg::ABUS_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // interrupt
   output logic irq_o,
   // analog side
   input wire logic comp_i,
   input wire logic rc_clk_i,
   output logic power_o,
   output logic sample_o,
   output logic [adcs_pkg::RES_W-1:0] dac_o,
   output logic [adcs_pkg::NUM_CHAN-1:0] chan_sel_o,
   output logic [adcs_pkg::NUM_CHAN-1:0] analog_en_o,
   output logic vref_neg_ext_o,
   output logic vref_pos_ext_o
);
   import adcs_pkg::*;

   if (TAD_CNT_W < 6) begin : g_chk
      $error("adcs_ctrl: TAD_CNT_W too small for divide by 64");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACQ = 3'b010,
      ST_CONV = 3'b100
   } adcs_state_t;

   // one-hot channel route, empty for codes past the last input
   function automatic logic [NUM_CHAN-1:0] chan_route(input logic [3:0] code);
      chan_route = (code < 4'(NUM_CHAN)) ? NUM_CHAN'(1) << code : '0;
   endfunction

   // analog map: each code past one frees one more input from the top
   function automatic logic [NUM_CHAN-1:0] pin_map(input logic [3:0] code);
      pin_map = (code <= 4'h1) ? '1 : ({NUM_CHAN{1'b1}} >> (code - 4'h1));
   endfunction

   // one successive approximation step on bit b
   function automatic logic [RES_W-1:0] sar_step(input logic [RES_W-1:0] t,
                                                 input logic [3:0] b, input logic keep);
      logic [RES_W-1:0] r;
      r = t;
      r[b] = keep;
      if (b != 4'h0) begin
         r[b-4'h1] = 1'b1;
      end
      sar_step = r;
   endfunction

   adcs_state_t st_r;
   adcs_state_t st_nxt;
   adcs_clk_chan_t ctl0_r;
   adcs_fmt_cfg_t ctl1_r;
   logic [2:0] acq_r;
   logic [RES_W-1:0] res_r;
   logic [RES_W-1:0] trial_r;
   logic [3:0] tad_cnt_r;
   logic [4:0] acq_cnt_r;
   logic [7:0] stat_r;
   logic [7:0] mask_r;
   logic comp_m_r;
   logic comp_s_r;
   logic tick;

   // apb decode
   wire logic [IDX_W-1:0] idx_w = paddr_i[ABUS_W-1:2];
   wire logic access_w = psel_i & penable_i;
   wire logic hit_w = (paddr_i[1:0] == 2'h0) &&
                      (idx_w == IDX_CLK_CHAN || idx_w == IDX_FMT_CFG ||
                       idx_w == IDX_RES_HIGH || idx_w == IDX_RES_LOW ||
                       idx_w == IDX_ACQ || idx_w == IDX_IRQ_STAT ||
                       idx_w == IDX_IRQ_MASK);
   wire logic done_w = access_w & pready_o;
   wire logic wr_w = done_w & pwrite_i & pstrb_i[0] & hit_w;
   wire logic rd_stat_w = done_w & ~pwrite_i & (idx_w == IDX_IRQ_STAT) & hit_w;
   wire logic wr0_w = wr_w & (idx_w == IDX_CLK_CHAN);
   wire logic wr1_w = wr_w & (idx_w == IDX_FMT_CFG);
   wire adcs_clk_chan_t wr0_data = pwdata_i[7:0];

   // justified views of the result
   wire logic [7:0] res_high_w = ctl1_r.result_justify ?
                                 {6'h00, res_r[9:8]} : res_r[9:2];
   wire logic [7:0] res_low_w = ctl1_r.result_justify ?
                                res_r[7:0] : {res_r[1:0], 6'h00};
   wire logic [7:0] acq_view_w = {2'h0, acq_r, 3'h0};
   wire logic [7:0] rd_mux_w = (idx_w == IDX_CLK_CHAN) ? ctl0_r :
                               (idx_w == IDX_FMT_CFG) ? ctl1_r :
                               (idx_w == IDX_RES_HIGH) ? res_high_w :
                               (idx_w == IDX_RES_LOW) ? res_low_w :
                               (idx_w == IDX_ACQ) ? acq_view_w :
                               (idx_w == IDX_IRQ_STAT) ? stat_r :
                               (idx_w == IDX_IRQ_MASK) ? mask_r : 8'h00;

   // channel code and sequencing terms
   wire logic [3:0] chan_w = {ctl0_r.channel_select_msb, ctl0_r.chan_low};
   wire logic tied_w = NARROW_PKG && (chan_w >= 4'h5) && (chan_w <= 4'h7);
   wire logic keep_w = comp_s_r | tied_w;
   wire logic start_w = (st_r == ST_IDLE) & wr0_w & wr0_data.go &
                        wr0_data.converter_power_on;
   wire logic abort_w = wr0_w & (~wr0_data.go | ~wr0_data.converter_power_on);
   wire logic fin_w = (st_r == ST_CONV) & tick & (tad_cnt_r == CONV_TADS - 4'h1);
   wire logic [4:0] acq_len_w = acq_tads(acq_r);

   // bit-period ticks run only while a conversion cycle is under way
   adcs_tad_gen #(
      .CNT_W(TAD_CNT_W)
   ) u_tad (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .run_i(st_r != ST_IDLE),
      .sel_i(ctl0_r.conv_clock_select),
      .halve_i(ctl1_r.clock_halve_select),
      .rc_clk_i(rc_clk_i),
      .tick_o(tick)
   );

   // sequencer next state; a software abort wins over a tick
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (start_w) begin
               st_nxt = (acq_len_w == 5'h00) ? ST_CONV : ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (abort_w) begin
               st_nxt = ST_IDLE;
            end else if (tick && acq_cnt_r == 5'h01) begin
               st_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (abort_w || fin_w) begin
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // comparator pin synchroniser; trials need a bit period of at least
   // four system clocks to be judged on a settled comparator
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         comp_m_r <= 1'b0;
         comp_s_r <= 1'b0;
      end else begin
         comp_m_r <= comp_i;
         comp_s_r <= comp_m_r;
      end
   end

   // state, counters and the approximation register
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         st_r <= ST_IDLE;
         acq_cnt_r <= 5'h00;
         tad_cnt_r <= 4'h0;
         trial_r <= RST_RESULT;
         res_r <= RST_RESULT;
      end else begin
         st_r <= st_nxt;
         if (start_w) begin
            acq_cnt_r <= acq_len_w;
         end else if (st_r == ST_ACQ && tick) begin
            acq_cnt_r <= acq_cnt_r - 5'h01;
         end
         if (st_r != ST_CONV) begin
            tad_cnt_r <= 4'h0;
            trial_r <= RST_RESULT | (10'h001 << (RES_W - 1));
         end else if (tick) begin
            tad_cnt_r <= tad_cnt_r + 4'h1;
            if (tad_cnt_r != 4'h0 && tad_cnt_r != CONV_TADS - 4'h1) begin
               trial_r <= sar_step(trial_r, 4'ha - tad_cnt_r, keep_w);
            end
         end
         if (fin_w && !abort_w) begin
            res_r <= trial_r;
         end
      end
   end

   // control registers; the go bit is cleared by hardware at the finish
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ctl0_r <= RST_CLK_CHAN;
         ctl1_r <= RST_FMT_CFG;
         acq_r <= RST_ACQ;
         mask_r <= RST_IRQ;
      end else begin
         if (wr0_w) begin
            ctl0_r <= wr0_data;
            ctl0_r.go <= start_w | (wr0_data.go & wr0_data.converter_power_on &
                                    ctl0_r.go & ~fin_w);
         end else if (fin_w) begin
            ctl0_r.go <= 1'b0;
         end
         if (wr1_w) begin
            ctl1_r <= pwdata_i[7:0];
         end
         if (wr_w && idx_w == IDX_ACQ) begin
            acq_r <= pwdata_i[ACQ_LSB+2:ACQ_LSB];
         end
         if (wr_w && idx_w == IDX_IRQ_MASK) begin
            mask_r <= pwdata_i[7:0];
         end
      end
   end

   // sticky status: set wins over the read that clears it
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         stat_r <= RST_IRQ;
         irq_o <= 1'b0;
      end else begin
         stat_r <= (rd_stat_w ? 8'h00 : stat_r) |
                   (8'(fin_w & ~abort_w) << DONE_BIT);
         irq_o <= |(stat_r & mask_r);
      end
   end

   // apb answer: one wait state, data and error from flops
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= access_w & ~pready_o;
         pslverr_o <= access_w & ~pready_o & ~hit_w;
         prdata_o <= (access_w && !pready_o && hit_w) ? {24'h00_0000, rd_mux_w} : 32'h0000_0000;
      end
   end

   // analog side controls
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         power_o <= 1'b0;
         sample_o <= 1'b0;
         dac_o <= RST_RESULT;
         chan_sel_o <= '0;
         analog_en_o <= '1;
         vref_neg_ext_o <= 1'b0;
         vref_pos_ext_o <= 1'b0;
      end else begin
         power_o <= ctl0_r.converter_power_on;
         sample_o <= ctl0_r.converter_power_on & (st_r != ST_CONV);
         dac_o <= (st_r == ST_CONV) ? trial_r : RST_RESULT;
         chan_sel_o <= ctl0_r.converter_power_on ? chan_route(chan_w) : '0;
         analog_en_o <= pin_map(ctl1_r.pin_analog_config);
         vref_neg_ext_o <= ctl1_r.neg_ref_select;
         vref_pos_ext_o <= ctl1_r.pos_ref_select;
      end
   end

   // helper counters watched only by assertions
   logic [4:0] ast_conv_r;
   logic [4:0] ast_acq_r;
   always_ff @(posedge mclk_i) begin
      if (!rstn_i || st_r == ST_IDLE) begin
         ast_conv_r <= 5'h00;
         ast_acq_r <= 5'h00;
      end else begin
         ast_conv_r <= ast_conv_r + 5'((st_r == ST_CONV) & tick);
         ast_acq_r <= ast_acq_r + 5'((st_r == ST_ACQ) & tick);
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   AST_GO_NEEDS_POWER: assert property (!ctl0_r.converter_power_on |-> !ctl0_r.go)
      else $error("go set while converter is off");
   AST_FINISH: assert property (fin_w && !abort_w |=> !ctl0_r.go && stat_r[DONE_BIT] &&
                                res_r == $past(trial_r))
      else $error("finish did not load result and clear go");
   AST_TWELVE_TADS: assert property (fin_w |-> ast_conv_r == 5'(CONV_TADS) - 5'h01)
      else $error("conversion length is not twelve bit periods");
   AST_ACQ_LEN: assert property (st_r == ST_ACQ && st_nxt == ST_CONV |->
                                 ast_acq_r + 5'h01 == acq_len_w)
      else $error("acquisition length wrong");
   AST_ACQ_SAMPLES: assert property (st_r == ST_ACQ |=> sample_o)
      else $error("not sampling during acquisition");
   AST_CHAN_NONE: assert property (chan_w[3:1] == 3'h7 |=> chan_sel_o == '0)
      else $error("unused channel code routed an input");
   AST_JUSTIFY: assert property (pready_o && !pwrite_i && idx_w == IDX_RES_HIGH &&
                                 ctl1_r.result_justify |-> prdata_o[7:2] == 6'h00)
      else $error("right-justified high byte not zero on top");
   AST_REFS: assert property (##1 vref_neg_ext_o == $past(ctl1_r.neg_ref_select) &&
                              vref_pos_ext_o == $past(ctl1_r.pos_ref_select))
      else $error("reference selects not followed");
   AST_POWER_OFF: assert property (!ctl0_r.converter_power_on && !start_w |=>
                                   !power_o && st_r == ST_IDLE)
      else $error("converter not shut down");
   AST_ALL_DIGITAL: assert property (ctl1_r.pin_analog_config == 4'hf |=> analog_en_o == '0)
      else $error("pin map not all digital");
endmodule
`default_nettype wire

// ===== sim/adcs_sh_model.sv
// behavioural sample-and-hold, comparator and internal rc oscillator
`timescale 1ns/10ps
`default_nettype none
module adcs_sh_model (
   // converter control side
   input wire logic power_i,
   input wire logic sample_i,
   input wire logic [adcs_pkg::RES_W-1:0] dac_i,
   input wire logic [adcs_pkg::NUM_CHAN-1:0] chan_sel_i,
   // level of input zero; input n sits n times 53 codes higher
   input wire logic [9:0] base_i,
   // answers to the sequencer
   output logic comp_o,
   output logic rc_clk_o
);
   import adcs_pkg::*;
   logic [9:0] held;
   initial begin
      held = 10'h000;
      rc_clk_o = 1'b0;
   end
   // rc oscillator runs free, phase unrelated to the system clock
   always #23 rc_clk_o = ~rc_clk_o;
   // hold capacitor tracks only while sampling, so a late route change cannot leak in
   always @(*) begin
      if (power_i && sample_i) begin
         for (int n = 0; n < NUM_CHAN; n++) begin
            if (chan_sel_i[n]) held = base_i + 10'(n * 53);
         end
      end
   end
   // high when the held level is not below the trial word
   assign comp_o = power_i && (held >= dac_i);
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
   import adcs_pkg::*;
   logic mclk_i, rstn_i, psel, penable, pwrite, pready, pslverr, irq, comp, rc_clk;
   logic power, sample, vneg, vpos, err, msk;
   logic [9:0] paddr, dac, base, lastv;
   logic [31:0] pwdata, prdata, rd, prdata2, rd2;
   logic [3:0] pstrb;
   logic [13:0] chan_sel, analog_en;
   logic [9:0] tab [8] = '{10'h113, 10'h20d, 10'h0a0, 10'h1d7, 10'h2b9, 10'h34c, 10'h161,
                           10'h3f5};
   int at [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int n_mismatch, checks, cyc;
   localparam logic [9:0] A_C0 = {IDX_CLK_CHAN, 2'b00};
   localparam logic [9:0] A_C1 = {IDX_FMT_CFG, 2'b00};
   localparam logic [9:0] A_RH = {IDX_RES_HIGH, 2'b00};
   localparam logic [9:0] A_RL = {IDX_RES_LOW, 2'b00};
   localparam logic [9:0] A_AQ = {IDX_ACQ, 2'b00};
   localparam logic [9:0] A_ST = {IDX_IRQ_STAT, 2'b00};
   localparam logic [9:0] A_MK = {IDX_IRQ_MASK, 2'b00};

   adcs_ctrl dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .comp_i(comp), .rc_clk_i(rc_clk), .power_o(power), .sample_o(sample), .dac_o(dac),
      .chan_sel_o(chan_sel), .analog_en_o(analog_en), .vref_neg_ext_o(vneg),
      .vref_pos_ext_o(vpos));
   adcs_sh_model sh_u (.power_i(power), .sample_i(sample), .dac_i(dac),
      .chan_sel_i(chan_sel), .base_i(base), .comp_o(comp), .rc_clk_o(rc_clk));
   // small-package twin on the same bus and comparator; only tied inputs differ
   adcs_ctrl #(.NARROW_PKG(1'b1)) nar_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .prdata_o(prdata2), .pready_o(), .pslverr_o(), .irq_o(),
      .comp_i(comp), .rc_clk_i(rc_clk), .power_o(), .sample_o(), .dac_o(), .chan_sel_o(),
      .analog_en_o(), .vref_neg_ext_o(), .vref_pos_ext_o());

   // 100 MHz system clock and a free cycle count for timing checks
   initial mclk_i = 1'b0;
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= cyc + 1;

   task automatic final_report();
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; the idle edge first keeps psel from being set twice in a step
   task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int k;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge mclk_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_mismatch++;
         final_report();
      end
      rd = prdata;
      rd2 = prdata2;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [9:0] a, input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, rd, e);
   endtask

   function automatic logic [7:0] c0(input logic [1:0] s, input logic [3:0] c,
                                     input logic g, input logic p);
      c0 = {s, c[2:0], g, c[3], p};
   endfunction

   // start, poll busy under a bound, then check time (divided clocks only), result, flag and irq
   task automatic conv(input logic [9:0] e);
      int t0, k, d;
      d = (e[9:8] == 2'b11) ? 0 : (2 << (2 * e[9:8])) << e[7];
      lastv = base + 10'(e[3:0] * 53);
      apb(1'b1, A_AQ, {2'b00, e[6:4], 3'b000});
      apb(1'b1, A_C1, {1'b1, e[7], 6'h00});
      apb(1'b1, A_C0, c0(e[9:8], e[3:0], 1'b0, 1'b1));
      t0 = cyc;
      apb(1'b1, A_C0, c0(e[9:8], e[3:0], 1'b1, 1'b1));
      k = 0;
      do begin
         apb(1'b0, A_C0, 8'h00);
         k++;
      end while (rd[2] !== 1'b0 && k < 1000);
      if (k >= 1000) begin
         n_mismatch++;
         final_report();
      end
      if (d > 0) begin
         chk("conv_min", 32'(cyc - t0 >= (at[e[6:4]] + 12) * d), 32'h1);
         chk("conv_max", 32'(cyc - t0 <= (at[e[6:4]] + 13) * d + 16), 32'h1);
      end
      rdchk("res_high", A_RH, {30'h0, lastv[9:8]});
      rdchk("res_low", A_RL, {24'h0, lastv[7:0]});
      chk("irq", 32'(irq), 32'(msk));
      rdchk("done_set", A_ST, 32'h1);
      rdchk("done_clr", A_ST, 32'h0);
      chk("irq_clr", 32'(irq), 32'h0);
   endtask

   initial begin
      n_mismatch = 0;
      checks = 0;
      cyc = 0;
      rstn_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      pstrb = 4'h1;
      base = 10'h0a5;
      msk = 1'b0;
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      chk("analog_en_rst", 32'(analog_en), 32'h3fff);
      rdchk("ctl0_rst", A_C0, 32'h0);
      rdchk("ctl1_rst", A_C1, 32'h0);
      rdchk("acq_rst", A_AQ, 32'h0);
      rdchk("mask_rst", A_MK, 32'h0);
      pstrb <= 4'h0;
      apb(1'b1, A_MK, 8'h01);
      pstrb <= 4'h1;
      rdchk("strobe_off", A_MK, 32'h0);
      apb(1'b0, 10'h3fc, 8'h00);
      chk("unmapped_err", 32'(err), 32'h1);
      apb(1'b1, 10'h07d, 8'h01);
      chk("misaligned_err", 32'(err), 32'h1);
      rdchk("misaligned_ignored", A_C0, 32'h0);
      apb(1'b1, A_RH, 8'hff);
      rdchk("res_read_only", A_RH, 32'h0);
      apb(1'b1, A_C0, 8'h04);
      rdchk("go_unpowered", A_C0, 32'h0);
      // every route code, pin map code and reference pair
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, A_C0, c0(2'b01, 4'(c), 1'b0, 1'b1));
         apb(1'b1, A_C1, {2'b00, 2'(c), 4'(c)});
         repeat (2) @(posedge mclk_i);
         chk("chan_sel", 32'(chan_sel), c < 14 ? 32'h1 << c : 32'h0);
         chk("analog_en", 32'(analog_en), 32'(14'h3fff >> (c < 2 ? 0 : c - 1)));
         chk("vref", 32'({vneg, vpos}), 32'(c % 4));
      end
      apb(1'b1, A_C0, c0(2'b01, 4'h3, 1'b0, 1'b0));
      repeat (2) @(posedge mclk_i);
      chk("off_state", 32'({power, sample, chan_sel}), 32'h0);
      // clock sources, acquisition codes, irq masked then unmasked
      for (int i = 0; i < 8; i++) begin
         if (i == 1) begin
            msk = 1'b1;
            apb(1'b1, A_MK, 8'h01);
         end
         conv(tab[i]);
      end
      apb(1'b1, A_C1, 8'h00);
      rdchk("left_high", A_RH, {24'h0, lastv[9:2]});
      chk("tied_high", rd2, {24'h0, FULL_SCALE[9:2]});
      rdchk("left_low", A_RL, {24'h0, lastv[1:0], 6'h00});
      chk("tied_low", rd2, {24'h0, FULL_SCALE[1:0], 6'h00});
      // long acquisition is seen as sampling, then aborted
      apb(1'b1, A_AQ, 8'h38);
      apb(1'b1, A_C1, 8'h40);
      apb(1'b1, A_C0, c0(2'b10, 4'h2, 1'b1, 1'b1));
      repeat (40) @(posedge mclk_i);
      chk("acq_sampling", 32'({sample, dac}), 32'h400);
      rdchk("busy", A_C0, 32'(c0(2'b10, 4'h2, 1'b1, 1'b1)));
      apb(1'b1, A_C0, c0(2'b10, 4'h2, 1'b0, 1'b1));
      repeat (2100) @(posedge mclk_i);
      rdchk("abort_flag", A_ST, 32'h0);
      // reset in mid acquisition
      apb(1'b1, A_C0, c0(2'b10, 4'h2, 1'b1, 1'b1));
      repeat (30) @(posedge mclk_i);
      rstn_i <= 1'b0;
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      chk("rst_outputs", 32'({power, analog_en}), 32'h3fff);
      rdchk("rst_ctl0", A_C0, 32'h0);
      // long enough for the cut conversion to have finished had it survived
      repeat (2100) @(posedge mclk_i);
      rdchk("rst_flag", A_ST, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
